//--- verilog/spi_flash_cmd_pkg.sv
`default_nettype none
package spi_flash_cmd_pkg;

    // System clock
    localparam int CLK_FREQ_MHZ = 50;

    // Opcodes
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_FULL_ERASE_A = 8'h60;
    localparam logic [7:0] OP_FULL_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_SLEEP        = 8'hB9;
    localparam logic [7:0] OP_WAKE_ID      = 8'hAB;
    localparam logic [7:0] OP_MAKER_PART   = 8'h90;
    localparam logic [7:0] OP_THREE_BYTE   = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID    = 8'h4B;

    // Frame bit counter; it saturates so a long frame never wraps
    localparam int         BIT_CNT_W    = 6;
    localparam logic [5:0] BIT_CNT_MAX  = 6'h3F;
    localparam logic [5:0] OPCODE_BITS  = 6'h08;
    localparam logic [5:0] ADDR_LAST    = 6'h20;
    localparam logic [5:0] DUMMY4_LAST  = 6'h28;

    // Output index and the last index of each repeating answer
    localparam int         IDX_W          = 7;
    localparam logic [6:0] LAST_WAKE_ID   = 7'h07;
    localparam logic [6:0] LAST_MAKER_PRT = 7'h0F;
    localparam logic [6:0] LAST_THREE_BYT = 7'h17;
    localparam logic [6:0] LAST_UNIQUE    = 7'h7F;
    localparam logic [6:0] IDX_TOP        = 7'h7F;

    // Delays, in ns as given, and cycles rounded up (least times)
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int WAKE_DELAY_NS        = 20000;
    localparam int SLEEP_ENTRY_CYC =
        (SLEEP_ENTRY_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int WAKE_CYC =
        (WAKE_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int         PWR_CNT_W = 16;
    localparam logic [15:0] SLEEP_ENTRY_LOAD = 16'(SLEEP_ENTRY_CYC - 1);
    localparam logic [15:0] WAKE_LOAD        = 16'(WAKE_CYC - 1);

    // Power state, one-hot
    typedef enum logic [3:0] {
        PWR_AWAKE    = 4'b0001,
        PWR_ENTERING = 4'b0010,
        PWR_SLEEP    = 4'b0100,
        PWR_WAKING   = 4'b1000
    } pwr_state_t;
    localparam int PWR_SLEEP_BIT = 2;

endpackage
`default_nettype wire

//--- verilog/pin_sampler.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sampler (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_cs_b,
    input  wire logic i_sclk,
    input  wire logic i_si,
    output logic      o_cs_b_s,
    output logic      o_si_s,
    output logic      o_sclk_rise,
    output logic      o_sclk_fall
);

    logic [1:0] cs_b_sync_reg;
    logic [1:0] si_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic       sclk_prev_reg;

    // Two flops per pin; chip select idles high so it resets high
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_b_sync_reg <= 2'h3;
            si_sync_reg   <= 2'h0;
            sclk_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
        end else begin
            cs_b_sync_reg <= {cs_b_sync_reg[0], i_cs_b};
            si_sync_reg   <= {si_sync_reg[0], i_si};
            sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end

    // Edges seen on the settled stage only, so data and clock stay aligned
    assign o_cs_b_s    = cs_b_sync_reg[1];
    assign o_si_s      = si_sync_reg[1];
    assign o_sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
    assign o_sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;

endmodule // pin_sampler
`default_nettype wire

//--- verilog/spi_flash_erase_sleep_id_cmds.sv
`timescale 1ns/1ns
`default_nettype none
module spi_flash_erase_sleep_id_cmds
    import spi_flash_cmd_pkg::*;
#(
    parameter int unsigned   FULL_ERASE_TIME_US = 10000,
    parameter int unsigned   FULL_ERASE_CYCLES  = FULL_ERASE_TIME_US * CLK_FREQ_MHZ,
    parameter logic [7:0]    MAKER_ID           = 8'h5A,  // Arbitrary value
    parameter logic [7:0]    DEVICE_ID          = 8'h3C,  // Arbitrary value
    parameter logic [7:0]    MEMORY_TYPE        = 8'h41,  // Arbitrary value
    parameter logic [7:0]    CAPACITY           = 8'h16,  // Arbitrary value
    parameter logic [127:0]  UNIQUE_ID          = 128'h0123456789ABCDEFFEDCBA9876543210  // Arbitrary
)(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_cs_b,
    input  wire logic       i_sclk,
    input  wire logic       i_si,
    input  wire logic [2:0] i_block_protect_field,
    input  wire logic       i_protect_invert_bit,
    input  wire logic       i_cycle_busy,
    input  wire logic       i_soft_reset,
    output logic            o_so,
    output logic            o_so_oe,
    output logic            o_busy_flag,
    output logic            o_write_latch_flag,
    output logic            o_sleep
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    localparam int ERASE_W = $clog2(FULL_ERASE_CYCLES + 1);

    if (FULL_ERASE_CYCLES < 1 || ERASE_W > 32) begin : g_bad_erase
        $error("FULL_ERASE_CYCLES out of range");
    end
    if (SLEEP_ENTRY_CYC < 1 || WAKE_CYC < 1 || WAKE_CYC > 65536) begin : g_bad_delay
        $error("Power delays out of range");
    end

    localparam logic [ERASE_W-1:0] ERASE_LOAD = ERASE_W'(FULL_ERASE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Commands that answer with identification data
    function automatic logic is_id_cmd(input logic [7:0] op);
        return (op == OP_WAKE_ID) || (op == OP_MAKER_PART) ||
               (op == OP_THREE_BYTE) || (op == OP_UNIQUE_ID);
    endfunction

    // Input bits that precede the answer
    function automatic logic [BIT_CNT_W-1:0] out_start(input logic [7:0] op);
        logic [BIT_CNT_W-1:0] s;
        s = ADDR_LAST;
        if (op == OP_THREE_BYTE) begin
            s = OPCODE_BITS;
        end else if (op == OP_UNIQUE_ID) begin
            s = DUMMY4_LAST;
        end
        return s;
    endfunction

    // Last index before the answer repeats
    function automatic logic [IDX_W-1:0] out_last(input logic [7:0] op);
        logic [IDX_W-1:0] l;
        l = LAST_UNIQUE;
        if (op == OP_WAKE_ID) begin
            l = LAST_WAKE_ID;
        end else if (op == OP_MAKER_PART) begin
            l = LAST_MAKER_PRT;
        end else if (op == OP_THREE_BYTE) begin
            l = LAST_THREE_BYT;
        end
        return l;
    endfunction

    // Answer bit, MSB first; shorter answers are left aligned
    function automatic logic id_bit(input logic [7:0] op, input logic [IDX_W-1:0] idx);
        logic [127:0] v;
        v = UNIQUE_ID;
        if (op == OP_WAKE_ID) begin
            v = {DEVICE_ID, 120'h0};
        end else if (op == OP_MAKER_PART) begin
            v = {MAKER_ID, DEVICE_ID, 112'h0};
        end else if (op == OP_THREE_BYTE) begin
            v = {MAKER_ID, MEMORY_TYPE, CAPACITY, 104'h0};
        end
        return v[IDX_TOP - idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling

    logic cs_b_s;
    logic si_s;
    logic sclk_rise;
    logic sclk_fall;

    pin_sampler u_pins (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_cs_b      (i_cs_b),
        .i_sclk      (i_sclk),
        .i_si        (i_si),
        .o_cs_b_s    (cs_b_s),
        .o_si_s      (si_s),
        .o_sclk_rise (sclk_rise),
        .o_sclk_fall (sclk_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and decode

    logic                 cs_prev_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [7:0]           shift_reg;
    logic [7:0]           opcode_reg;
    logic                 addr_zero_reg;
    logic [IDX_W-1:0]     out_idx_reg;
    logic                 so_reg;
    logic                 so_oe_reg;
    logic                 write_latch_flag_reg;
    logic                 erase_active_reg;
    logic [ERASE_W-1:0]   erase_cnt_reg;
    logic                 busy_reg;
    pwr_state_t           pwr_reg;
    logic [PWR_CNT_W-1:0] pwr_cnt_reg;

    logic cs_rise;
    logic busy_now;
    logic frame_ok;
    logic opcode_only;
    logic protect_ok;
    logic wel_set;
    logic erase_go;
    logic sleep_go;
    logic wake_go;
    logic out_live;

    assign cs_rise  = cs_b_s & ~cs_prev_reg;
    assign busy_now = erase_active_reg | i_cycle_busy;

    // While busy nothing here is decoded; asleep only the wake opcode
    assign frame_ok = !busy_now &&
                      ((pwr_reg == PWR_AWAKE) ||
                       (pwr_reg == PWR_SLEEP && opcode_reg == OP_WAKE_ID));

    // A frame of exactly eight bits; anything longer is discarded
    assign opcode_only = cs_rise && (bit_cnt_reg == OPCODE_BITS);

    assign protect_ok = ((i_block_protect_field == 3'h0) && !i_protect_invert_bit) ||
                        ((i_block_protect_field == 3'h7) && i_protect_invert_bit);

    assign wel_set  = opcode_only && frame_ok && (opcode_reg == OP_WRITE_UNLOCK);
    assign erase_go = opcode_only && frame_ok && write_latch_flag_reg && protect_ok &&
                      ((opcode_reg == OP_FULL_ERASE_A) || (opcode_reg == OP_FULL_ERASE_B));
    assign sleep_go = opcode_only && frame_ok && (opcode_reg == OP_SLEEP);
    assign wake_go  = cs_rise && (bit_cnt_reg >= OPCODE_BITS) && !busy_now &&
                      (pwr_reg == PWR_SLEEP) && (opcode_reg == OP_WAKE_ID);

    // Answer runs once all input bits are in; 90h needs a zero address
    assign out_live = !cs_b_s && frame_ok && (bit_cnt_reg >= OPCODE_BITS) &&
                      is_id_cmd(opcode_reg) &&
                      (bit_cnt_reg >= out_start(opcode_reg)) &&
                      (addr_zero_reg || opcode_reg != OP_MAKER_PART);

    ////////////////////////////////////////////////////////////////////////////
    // Frame capture

    // Bits clocked in on rising serial clock; deselect clears the frame
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_prev_reg   <= 1'b1;
            bit_cnt_reg   <= '0;
            shift_reg     <= 8'h00;
            opcode_reg    <= 8'h00;
            addr_zero_reg <= 1'b1;
        end else begin
            cs_prev_reg <= cs_b_s;
            if (cs_b_s) begin
                bit_cnt_reg   <= '0;
                addr_zero_reg <= 1'b1;
            end else if (sclk_rise) begin
                shift_reg <= {shift_reg[6:0], si_s};
                if (bit_cnt_reg != BIT_CNT_MAX) begin
                    bit_cnt_reg <= bit_cnt_reg + 6'h01;
                end
                if (bit_cnt_reg == OPCODE_BITS - 6'h01) begin
                    opcode_reg <= {shift_reg[6:0], si_s};
                end
                if (bit_cnt_reg >= OPCODE_BITS && bit_cnt_reg < ADDR_LAST && si_s) begin
                    addr_zero_reg <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial answer

    // Driven on falling serial clock; repeats until deselect
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_idx_reg <= '0;
            so_reg      <= 1'b0;
            so_oe_reg   <= 1'b0;
        end else if (cs_b_s) begin
            out_idx_reg <= '0;
            so_oe_reg   <= 1'b0;
        end else if (sclk_fall && out_live) begin
            so_reg    <= id_bit(opcode_reg, out_idx_reg);
            so_oe_reg <= 1'b1;
            if (out_idx_reg == out_last(opcode_reg)) begin
                out_idx_reg <= '0;
            end else begin
                out_idx_reg <= out_idx_reg + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write latch flag

    // Set wins over clear; set and erase never share a frame, a soft reset can
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            write_latch_flag_reg <= 1'b0;
        end else if (wel_set) begin
            write_latch_flag_reg <= 1'b1;
        end else if (erase_go || i_soft_reset) begin
            write_latch_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Full-array erase timer

    // Counts the erase time; the array itself is outside this block
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            erase_active_reg <= 1'b0;
            erase_cnt_reg    <= '0;
        end else if (erase_go) begin
            erase_active_reg <= 1'b1;
            erase_cnt_reg    <= ERASE_LOAD;
        end else if (erase_active_reg) begin
            if (erase_cnt_reg == '0) begin
                erase_active_reg <= 1'b0;
            end else begin
                erase_cnt_reg <= erase_cnt_reg - ERASE_W'(1);
            end
        end
    end

    // Busy covers this erase and any other cycle running elsewhere
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= erase_go | erase_active_reg | i_cycle_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state

    // Reset lands in standby; sleep only via the sleep opcode
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pwr_reg     <= PWR_AWAKE;
            pwr_cnt_reg <= '0;
        end else if (i_soft_reset) begin
            pwr_reg     <= PWR_AWAKE;
            pwr_cnt_reg <= '0;
        end else begin
            unique case (pwr_reg)
                PWR_AWAKE: begin
                    if (sleep_go) begin
                        pwr_reg     <= PWR_ENTERING;
                        pwr_cnt_reg <= SLEEP_ENTRY_LOAD;
                    end
                end
                PWR_ENTERING: begin
                    if (pwr_cnt_reg == '0) begin
                        pwr_reg <= PWR_SLEEP;
                    end else begin
                        pwr_cnt_reg <= pwr_cnt_reg - 16'h0001;
                    end
                end
                PWR_SLEEP: begin
                    if (wake_go) begin
                        pwr_reg     <= PWR_WAKING;
                        pwr_cnt_reg <= WAKE_LOAD;
                    end
                end
                PWR_WAKING: begin
                    // Commands are ignored until the wake delay expires
                    if (pwr_cnt_reg == '0) begin
                        pwr_reg <= PWR_AWAKE;
                    end else begin
                        pwr_cnt_reg <= pwr_cnt_reg - 16'h0001;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_so               = so_reg;
    assign o_so_oe            = so_oe_reg;
    assign o_busy_flag        = busy_reg;
    assign o_write_latch_flag = write_latch_flag_reg;
    assign o_sleep            = pwr_reg[PWR_SLEEP_BIT];

endmodule // spi_flash_erase_sleep_id_cmds
`default_nettype wire

//--- dv/spi_flash_cmds_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module spi_flash_cmds_monitor (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_b,
    input wire logic       i_cs_b,
    input wire logic       i_sclk,
    input wire logic       i_si,
    input wire logic [2:0] i_block_protect_field,
    input wire logic       i_protect_invert_bit,
    input wire logic       i_cycle_busy,
    input wire logic       i_soft_reset,
    input wire logic       o_so,
    input wire logic       o_so_oe,
    input wire logic       o_busy_flag,
    input wire logic       o_write_latch_flag,
    input wire logic       o_sleep
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////
    // Erase start only with latch set and protection open; latch clear at end; busy covers other cycles
    erase_on_cs_a: assert property ($rose(o_busy_flag) && !$past(i_cycle_busy) |-> i_cs_b && $past(i_cs_b, 3))
        else $error("erase started without chip select high");
    erase_latch_a: assert property ($rose(o_busy_flag) && !$past(i_cycle_busy)
        |-> $past(o_write_latch_flag, 2) || $past(o_write_latch_flag, 3))
        else $error("erase started without write latch");
    erase_protect_a: assert property ($rose(o_busy_flag) && !$past(i_cycle_busy)
        |-> (i_block_protect_field == 3'h0 && !i_protect_invert_bit)
         || (i_block_protect_field == 3'h7 && i_protect_invert_bit))
        else $error("erase started under protection");
    latch_cleared_a: assert property ($fell(o_busy_flag) && !$past(i_cycle_busy, 2) |-> !o_write_latch_flag)
        else $error("write latch still set at erase end");
    busy_mirror_a: assert property ($past(i_cycle_busy) |-> o_busy_flag)
        else $error("busy flag misses running cycle");
    ////////////////////////////////////////////////////////////////////////
    // Output driver and power state
    drive_not_busy_a: assert property ($rose(o_so_oe) |-> !o_busy_flag)
        else $error("output driven while busy");
    oe_release_a: assert property (i_cs_b [*6] |-> !o_so_oe)
        else $error("output still driven after deselect");
    sleep_entry_a: assert property ($rose(o_sleep) |-> i_cs_b && $past(i_cs_b, 150) && !o_busy_flag)
        else $error("sleep entered early or while busy");
    sleep_hold_a: assert property (o_sleep && i_cs_b && $past(i_cs_b, 6) && !i_soft_reset |=> o_sleep)
        else $error("sleep left without command");
    // Main scenarios reached
    cover property ($rose(o_busy_flag));
    cover property ($rose(o_sleep));
    cover property ($rose(o_so_oe));
endmodule // spi_flash_cmds_monitor
bind spi_flash_erase_sleep_id_cmds spi_flash_cmds_monitor u_spi_flash_cmds_monitor (.*);
`default_nettype wire

//--- dv/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_so,
    output var logic  o_cs_b,
    output var logic  o_sclk,
    output var logic  o_si
);
    // Idle bus: deselected, clock parked low between frames
    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_si   = 1'b0;
    end
    // Half of the 160 ns serial period, moved on falling sys edges
    task automatic half();
        repeat (4) @(negedge i_clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // One frame: n_tx bits out MSB first, then n_rx bits captured on rising edges
    task automatic xfer(input logic [39:0] tx, input int n_tx, input int n_rx, output logic [127:0] rx);
        rx = '0;
        o_cs_b = 1'b0;
        half();
        for (int i = 0; i < n_tx + n_rx; i++) begin
            o_si = (i < n_tx) ? tx[39-i] : ~o_si; // Nonsense on SI once bits are done
            half();
            o_sclk = 1'b1;
            if (i >= n_tx) begin
                rx = {rx[126:0], i_so};
            end
            half();
            o_sclk = 1'b0;
        end
        half();
        o_cs_b = 1'b1;
        o_si   = ~o_si;
        repeat (8) half(); // Gap keeps the deselect long enough to be decoded
    endtask
endmodule // spi_host_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import spi_flash_cmd_pkg::*;
    localparam logic [7:0]   MAKER = 8'hC3; // Arbitrary value
    localparam logic [7:0]   DEV   = 8'h96; // Arbitrary value
    localparam logic [7:0]   MTYP  = 8'h40; // Arbitrary value
    localparam logic [7:0]   CAP   = 8'h17; // Arbitrary value
    localparam logic [127:0] UID   = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F; // Arbitrary value
    typedef struct {logic [39:0] tx; int ntx; int nrx; logic oe; logic [127:0] exp;} row_t;
    logic clk = 1'b0, rst_b = 1'b0, cyc_busy = 1'b0, soft_rst = 1'b0, inv = 1'b0, oe_seen = 1'b0;
    logic [2:0]   prot = 3'h0;
    logic [127:0] rx;
    int           errors = 0, n_tests = 0;
    row_t         rows[5];
    wire logic    cs_b, sclk, si, so, so_oe, busy, write_latch_flag, sleep, so_line;
    ////////////////////////////////////////////////////////////////////////
    // Clock, drive observation and instances
    always #10 clk = ~clk;
    always @(posedge clk) if (so_oe === 1'b1) oe_seen <= 1'b1;
    // A released line shows the inverse, so stale data can never pass as an answer
    assign so_line = (so_oe === 1'b1) ? so : ~so;
    spi_host_model u_spi_host_model (.i_clk_sys(clk), .i_so(so_line), .o_cs_b(cs_b), .o_sclk(sclk), .o_si(si));
    spi_flash_erase_sleep_id_cmds #(.FULL_ERASE_CYCLES(3000), .MAKER_ID(MAKER), .DEVICE_ID(DEV),
        .MEMORY_TYPE(MTYP), .CAPACITY(CAP), .UNIQUE_ID(UID)) u_spi_flash_erase_sleep_id_cmds (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_sclk(sclk), .i_si(si),
        .i_block_protect_field(prot), .i_protect_invert_bit(inv), .i_cycle_busy(cyc_busy),
        .i_soft_reset(soft_rst), .o_so(so), .o_so_oe(so_oe), .o_busy_flag(busy),
        .o_write_latch_flag(write_latch_flag), .o_sleep(sleep));
    ////////////////////////////////////////////////////////////////////////
    // Compare, frame and wait helpers
    task automatic chk(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %b got %b", name, exp, got);
        end
    endtask
    task automatic chkd(input string name, input logic [127:0] exp, input logic [127:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    function automatic logic [39:0] op(input logic [7:0] c);
        return {c, 32'h0};
    endfunction
    task automatic run(input logic [39:0] tx, input int ntx, input int nrx);
        oe_seen = 1'b0;
        u_spi_host_model.xfer(tx, ntx, nrx, rx);
    endtask
    // Bounded wait; only the erase timer is long enough to need one
    task automatic wait_idle();
        int k;
        for (k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge clk);
        if (k == 5000) begin
            errors++;
            results();
        end
    endtask
    task automatic results();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rows = '{'{op(OP_THREE_BYTE), 8, 32, 1'b1, 128'({MAKER, MTYP, CAP, MAKER})},
                 '{op(OP_MAKER_PART), 32, 32, 1'b1, 128'({MAKER, DEV, MAKER, DEV})},
                 '{{OP_MAKER_PART, 32'h100}, 32, 16, 1'b0, 128'h0},
                 '{op(OP_WAKE_ID), 32, 16, 1'b1, 128'({DEV, DEV})},
                 '{op(OP_UNIQUE_ID), 40, 128, 1'b1, UID}};
        repeat (6) @(negedge clk);
        chk("sleep", 1'b0, sleep);
        chk("wel", 1'b0, write_latch_flag);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        // Identification reads, each answer checked bit for bit
        foreach (rows[i]) begin
            run(rows[i].tx, rows[i].ntx, rows[i].nrx);
            chk("drive", rows[i].oe, oe_seen);
            chk("release", 1'b0, so_oe);
            if (rows[i].oe) chkd("id", rows[i].exp, rx);
        end
        chk("sleep", 1'b0, sleep);
        // Erase refused: no latch, overlong frame, protection closed
        run(op(OP_FULL_ERASE_A), 8, 0);
        chk("busy", 1'b0, busy);
        run(op(OP_WRITE_UNLOCK), 8, 0);
        run(op(OP_FULL_ERASE_A), 16, 0);
        chk("busy", 1'b0, busy);
        prot = 3'h1;
        run(op(OP_FULL_ERASE_A), 8, 0);
        chk("busy", 1'b0, busy);
        chk("wel", 1'b1, write_latch_flag);
        // Both erase opcodes; requests during the erase must stay inert
        for (int j = 0; j < 2; j++) begin
            prot = j[0] ? 3'h7 : 3'h0;
            inv = j[0];
            run(op(OP_WRITE_UNLOCK), 8, 0);
            run(op(j[0] ? OP_FULL_ERASE_B : OP_FULL_ERASE_A), 8, 0);
            chk("busy", 1'b1, busy);
            chk("wel", 1'b0, write_latch_flag);
            run(op(OP_THREE_BYTE), 8, 16);
            chk("drive", 1'b0, oe_seen);
            run(op(OP_WAKE_ID), 32, 16);
            chk("drive", 1'b0, oe_seen);
            run(op(OP_SLEEP), 8, 0);
            wait_idle();
            repeat (200) @(negedge clk);
            chk("sleep", 1'b0, sleep);
        end
        // Sleep refused while another cycle runs
        cyc_busy = 1'b1;
        run(op(OP_SLEEP), 8, 0);
        chk("busy", 1'b1, busy);
        cyc_busy = 1'b0;
        repeat (200) @(negedge clk);
        chk("sleep", 1'b0, sleep);
        // Sleep: entry delay, ignored commands, soft reset, wake delay
        run(op(OP_SLEEP), 8, 0);
        chk("sleep", 1'b0, sleep);
        repeat (150) @(negedge clk);
        chk("sleep", 1'b1, sleep);
        run(op(OP_WRITE_UNLOCK), 8, 0);
        chk("wel", 1'b0, write_latch_flag);
        run(op(OP_MAKER_PART), 32, 16);
        chk("drive", 1'b0, oe_seen);
        soft_rst = 1'b1;
        @(negedge clk);
        soft_rst = 1'b0;
        @(negedge clk);
        chk("sleep", 1'b0, sleep);
        run(op(OP_SLEEP), 8, 0);
        repeat (150) @(negedge clk);
        run(op(OP_WAKE_ID), 8, 0);
        chk("sleep", 1'b0, sleep);
        run(op(OP_THREE_BYTE), 8, 16);
        chk("drive", 1'b0, oe_seen);
        repeat (1000) @(negedge clk);
        run(op(OP_THREE_BYTE), 8, 24);
        chkd("id", 128'({MAKER, MTYP, CAP}), rx);
        // Asleep with the latch set: erase must stay inert, then reset mid-run
        run(op(OP_WRITE_UNLOCK), 8, 0);
        run(op(OP_SLEEP), 8, 0);
        repeat (150) @(negedge clk);
        chk("sleep", 1'b1, sleep);
        run(op(OP_FULL_ERASE_A), 8, 0);
        chk("busy", 1'b0, busy);
        chk("wel", 1'b1, write_latch_flag);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        chk("sleep", 1'b0, sleep);
        chk("wel", 1'b0, write_latch_flag);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        run(op(OP_THREE_BYTE), 8, 24);
        chkd("id", 128'({MAKER, MTYP, CAP}), rx);
        results();
    end
endmodule // tb
`default_nettype wire
